// *** rtl/wdog_params.svh ***
// timing constants for the processor watchdog supervisor
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH
`define CLK_PERIOD_PS     4000
`define WD_INTERVAL_MS    1500
`define RST_INTERVAL_MS   200
`define PS_PER_MS         64'd1000000000
`define WD_INTERVAL_CYC   ((`WD_INTERVAL_MS * `PS_PER_MS) / `CLK_PERIOD_PS)
`define RST_INTERVAL_CYC  ((`RST_INTERVAL_MS * `PS_PER_MS) / `CLK_PERIOD_PS)
`define CNT_W             32
`endif

// *** rtl/wdog_pkg.sv ***
// types for the processor watchdog supervisor
package wdog_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WATCH,
        ST_FAULT
    } wd_state_t;

    typedef struct packed {
        logic o;
        logic oe;
    } od_pin_t;
endpackage

// *** rtl/toggle_edge_detect.sv ***
// two-flop synchroniser and edge detector for the toggle input
`timescale 1ns/1ps
module toggle_edge_detect (
    input  wire logic CLK,
    input  wire logic RESETN,
    input  wire logic din,
    output logic      edge_seen
);
    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    always_comb begin
        next_meta = din;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // rising or falling edge
    assign edge_seen = sync ^ prev;
endmodule

// *** rtl/processor_watchdog_supervisor.sv ***
// watchdog supervisor for a processor that toggles a heartbeat pin
`timescale 1ns/1ps
`include "wdog_params.svh"
module processor_watchdog_supervisor #(
    parameter logic [`CNT_W-1:0] WD_CYCLES  = `CNT_W'(`WD_INTERVAL_CYC),
    parameter logic [`CNT_W-1:0] RST_CYCLES = `CNT_W'(`RST_INTERVAL_CYC)
) (
    input  wire logic CLK,
    input  wire logic RESETN,
    input  wire logic WATCHDOG_TOGGLE_INPUT,
    output logic      WATCHDOG_FAULT_OUTPUT_O,
    output logic      WATCHDOG_FAULT_OUTPUT_OE,
    output logic      WATCHDOG_FAULT_ACTIVE
);
    import wdog_pkg::*;

    // counter width
    localparam int W = `CNT_W;

    // state group
    wd_state_t    state;
    wd_state_t    next_state;

    // interval counter group
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // open-drain pin and fault status group
    od_pin_t      pin;
    od_pin_t      next_pin;
    logic         active;
    logic         next_active;

    // decoded events
    logic         edge_seen;
    logic         watch_done;
    logic         reset_done;
    logic         restart;
    logic         enter_fault;
    logic         leave_fault;
    logic [W-1:0] limit;

    // true while the reset interval runs
    function automatic logic is_faulted(input wd_state_t s);
        logic f;
        f = (s == ST_FAULT);
        return f;
    endfunction

    // last cycle of an interval of len cycles
    function automatic logic last_cycle(
        input logic [W-1:0] cnt,
        input logic [W-1:0] len
    );
        logic [W-1:0] stop;
        stop = (len == '0) ? '0 : len - W'(1);
        return cnt >= stop;
    endfunction

    // cycles timed by the given state
    function automatic logic [W-1:0] interval_len(input wd_state_t s);
        logic [W-1:0] len;
        len = WD_CYCLES;
        if (is_faulted(s)) begin
            len = RST_CYCLES;
        end
        return len;
    endfunction

    // pin drive: pulled low only while faulted
    function automatic od_pin_t pin_for(input wd_state_t s);
        od_pin_t p;
        p.o  = 1'b0;
        p.oe = is_faulted(s);
        return p;
    endfunction

    // synchronised toggle edges
    toggle_edge_detect u_edge (
        .CLK       (CLK),
        .RESETN    (RESETN),
        .din       (WATCHDOG_TOGGLE_INPUT),
        .edge_seen (edge_seen)
    );

    // length of the running interval
    always_comb begin
        limit = interval_len(state);
    end

    // events of the current interval
    always_comb begin
        watch_done  = 1'b0;
        reset_done  = 1'b0;
        restart     = 1'b0;
        enter_fault = 1'b0;
        leave_fault = 1'b0;
        unique case (state)
            ST_IDLE: begin
                restart = 1'b1;
            end

            ST_WATCH: begin
                watch_done  = last_cycle(count, limit);
                restart     = edge_seen;
                enter_fault = watch_done && !edge_seen;
            end

            ST_FAULT: begin
                reset_done  = last_cycle(count, limit);
                restart     = edge_seen || reset_done;
                leave_fault = restart;
            end

            default: begin
                restart = 1'b1;
            end
        endcase
    end

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                next_state = ST_WATCH;
            end

            ST_WATCH: begin
                if (enter_fault) begin
                    next_state = ST_FAULT;
                end
            end

            ST_FAULT: begin
                if (leave_fault) begin
                    next_state = ST_WATCH;
                end
            end

            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // next count, cleared at every interval start
    always_comb begin
        next_count = count + W'(1);
        if (restart) begin
            next_count = '0;
        end else if (enter_fault) begin
            next_count = '0;
        end
    end

    // next pin drive and fault status
    always_comb begin
        next_pin    = pin_for(next_state);
        next_active = is_faulted(next_state);
    end

    // state register
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // interval counter
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // open-drain pin register
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pin.o  <= 1'b0;
            pin.oe <= 1'b0;
        end else begin
            pin.o  <= next_pin.o;
            pin.oe <= next_pin.oe;
        end
    end

    // fault status register
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            active <= 1'b0;
        end else begin
            active <= next_active;
        end
    end

    // outputs straight from flops
    assign WATCHDOG_FAULT_OUTPUT_O  = pin.o;
    assign WATCHDOG_FAULT_OUTPUT_OE = pin.oe;
    assign WATCHDOG_FAULT_ACTIVE    = active;
endmodule

// *** dv/wdog_props.sv ***
// assertions on the watchdog supervisor ports
`timescale 1ns/1ps
module wdog_props #(parameter int RST_CYCLES = 8) (
    input wire logic CLK, RESETN, WATCHDOG_TOGGLE_INPUT,
    input wire logic WATCHDOG_FAULT_OUTPUT_O, WATCHDOG_FAULT_ACTIVE,
    input wire logic WATCHDOG_FAULT_OUTPUT_OE
);
    wire t = WATCHDOG_TOGGLE_INPUT;
    wire oe = WATCHDOG_FAULT_OUTPUT_OE;
    localparam int RB = RST_CYCLES + 1;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence quiet8; !oe[*8]; endsequence
    pin_low_a: assert property (!WATCHDOG_FAULT_OUTPUT_O)
        else $error("fault pin driven high");
    boot_quiet_a: assert property ($rose(RESETN) |-> quiet8)
        else $error("fault right after reset");
    fault_end_a: assert property ($rose(oe) |-> ##[1:RB] !oe)
        else $error("fault held too long");
    early_rel_a: assert property (oe && $changed(t) |-> ##[1:6] !oe)
        else $error("toggle did not end fault");
    kick_restart_a: assert property (!oe && $changed(t) |-> ##6 quiet8)
        else $error("toggle did not restart interval");
    rel_quiet_a: assert property ($fell(oe) |=> quiet8)
        else $error("fault soon after release");
    active_copy_a: assert property (WATCHDOG_FAULT_ACTIVE == oe)
        else $error("fault status differs from pin drive");
endmodule
bind processor_watchdog_supervisor wdog_props
    #(.RST_CYCLES(RST_CYCLES)) u_props (.*);

// *** dv/proc_model.sv ***
// heartbeat model of the supervised processor
`timescale 1ns/1ps
module proc_model (input wire logic CLK, en, output logic wdt = 1'b0);
    logic [3:0] n = 4'h0;
    always @(negedge CLK) begin
        n <= (en && n != 4'h9) ? n + 4'h1 : 4'h0;
        if (en && n == 4'h0) wdt <= !wdt;
    end
endmodule

// *** dv/processor_watchdog_supervisor_bench.sv ***
// bench for the watchdog supervisor
`timescale 1ns/1ps
module processor_watchdog_supervisor_bench;
    logic CLK = 0, RESETN = 0, WATCHDOG_TOGGLE_INPUT, en = 0;
    logic WATCHDOG_FAULT_OUTPUT_O, WATCHDOG_FAULT_OUTPUT_OE;
    logic WATCHDOG_FAULT_ACTIVE;
    int n_mismatch = 0, compares = 0;
    initial forever #2 CLK = ~CLK;
    processor_watchdog_supervisor #(20, 8) u_dut (.*);
    proc_model u_proc (.CLK, .en, .wdt(WATCHDOG_TOGGLE_INPUT));
    task meas(string s, logic v, int lo, hi);
        int c;
        for (c = 0; WATCHDOG_FAULT_OUTPUT_OE !== v && c < 99; c++)
            @(negedge CLK);
        compares++;
        if (c < lo || c > hi) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %0d got %0d", s, lo, c);
        end
        compares++;
        if (WATCHDOG_FAULT_OUTPUT_O !== 1'b0) begin
            n_mismatch++;
            $display("CHECK FAILED fault data exp 0 got %b",
                     WATCHDOG_FAULT_OUTPUT_O);
        end
        compares++;
        if (WATCHDOG_FAULT_ACTIVE !== WATCHDOG_FAULT_OUTPUT_OE) begin
            n_mismatch++;
            $display("CHECK FAILED fault status exp %b got %b",
                     WATCHDOG_FAULT_OUTPUT_OE, WATCHDOG_FAULT_ACTIVE);
        end
    endtask
    task t_reset;
        en <= 0;
        RESETN <= 0;
        repeat (2) @(negedge CLK);
        RESETN <= 1;
        meas("reset expiry", 1, 21, 23);
        $display("reset test done");
    endtask
    task report_and_stop;
        $display("%0d compares %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task t_expire;
        meas("expiry", 1, 21, 21);
        meas("fault length", 0, 8, 8);
        meas("next expiry", 1, 20, 22);
        en <= 1;
        @(negedge CLK);
        en <= 0;
        meas("early release", 0, 3, 5);
        $display("expiry test done");
    endtask
    task t_kick;
        en <= 1;
        meas("kept quiet", 1, 99, 99);
        $display("kick test done");
    endtask
    initial begin
        repeat (20) @(negedge CLK);
        RESETN <= 1;
        t_expire;
        t_kick;
        t_reset;
        report_and_stop;
    end
    initial #3000 begin
        n_mismatch++;
        report_and_stop;
    end
endmodule
